// ===== logic/fcs_pkg.sv
/*
 * Constants for the flash code protection block: register addresses,
 * field positions, reset values and the preboot length.
 * Assumes one MPU clock domain with synchronous active-low reset.
 */
package fcs_pkg;
	// ==========================================================
	// register addresses
	localparam logic [7:0]  SFR_FLASH_CONTROL   = 8'hb2;
	localparam logic [15:0] XADR_CONFIG_ONE     = 16'h2005;
	// ==========================================================
	// field positions
	localparam int          FC_PREBOOT_BIT      = 7;
	localparam int          FC_LOCK_BIT         = 6;
	localparam int          FC_MEEN_BIT         = 1;
	localparam int          FC_PWE_BIT          = 0;
	localparam logic [7:0]  FC_STORED_MASK      = 8'h03;
	localparam int          CF1_ECK_OFF_BIT     = 5;
	localparam logic [7:0]  CF1_STORED_MASK     = 8'hbf;
	// ==========================================================
	// reset values
	localparam logic [7:0]  FC_RESET            = 8'h00;
	localparam logic [7:0]  CF1_RESET           = 8'h00;
	// ==========================================================
	// timing
	localparam int          PREBOOT_CYCLES      = 32;
	localparam int          PREBOOT_CNT_W       = 6;
	// ==========================================================
	// emulator command codes
	localparam logic [2:0]  EMU_OP_NONE         = 3'h0;
	localparam logic [2:0]  EMU_OP_READ         = 3'h1;
	localparam logic [2:0]  EMU_OP_WRITE        = 3'h2;
	localparam logic [2:0]  EMU_OP_PAGE_ERASE   = 3'h3;
	localparam logic [2:0]  EMU_OP_BULK_ERASE   = 3'h4;
	localparam logic [2:0]  EMU_OP_CONTROL      = 3'h5;

	typedef enum logic [1:0]
	{
		FCS_PREBOOT = 2'b00,
		FCS_RUN     = 2'b01,
		FCS_ERASED  = 2'b10
	} fcs_phase_t;
endpackage : fcs_pkg

// ===== logic/fcs_preboot_timer.sv
/*
 * Preboot cycle counter: counts MPU cycles from reset release and
 * reports when the preboot window has finished.
 * Assumes the owner gives it the same clock, enable and reset.
 */
module fcs_preboot_timer #(
	parameter int LENGTH = fcs_pkg::PREBOOT_CYCLES,
	parameter int CNT_W  = fcs_pkg::PREBOOT_CNT_W
) (
	input  wire logic i_core_clk,
	input  wire logic i_rst_n,
	input  wire logic i_ce,
	output logic      o_done
);
	import fcs_pkg::*;

	localparam logic [CNT_W-1:0] LAST = CNT_W'(LENGTH);

	logic [CNT_W-1:0] count;
	logic [CNT_W-1:0] next_count;

	// ==========================================================
	// counter
	always_comb
	begin
		next_count = count;
		if (count != LAST)
		begin
			next_count = count + CNT_W'(1);
		end
	end

	always_ff @(posedge i_core_clk)
	begin
		if (!i_rst_n)
		begin
			count <= '0;
		end
		else if (i_ce)
		begin
			count <= next_count;
		end
	end

	assign o_done = (count == LAST);
endmodule : fcs_preboot_timer

// ===== logic/fcs_lock.sv
/*
 * Flash code protection: the flash control SFR, the emulator clock
 * disable bit in configuration register one, and the gating of
 * emulator and processor flash operations.
 * Assumes the MPU SFR and external-RAM ports are single-cycle and
 * synchronous to i_core_clk; the flash engine reports bulk erase end.
 */
// Notes on behaviour
// - protected: emulator may only bulk erase
// - protection set only during preboot code
// - protection cleared by bulk erase then reset
// - bulk erase also clears engine program RAM
// - emulator inhibited for first 32 cycles
// - preboot flag readable at 0xb2 bit 7
// - emulator allowed after preboot ends
// - protection bit cleared on every reset
// - protection bit write-one-only
// - protected: no emulator code reads
// - protected: page zero erase refused
// - protected: page zero writes suppressed
// - emulator clock off bit blocks emulator
// - unused flash control bits hold nothing, read zero; config one stores all bits but 6
module fcs_lock (
	input  wire logic        i_core_clk,
	input  wire logic        i_rst_n,
	input  wire logic        i_ce,
	// sfr port
	input  wire logic [7:0]  i_sfr_addr,
	input  wire logic        i_sfr_wr,
	input  wire logic        i_sfr_rd,
	input  wire logic [7:0]  i_sfr_wdata,
	output logic      [7:0]  o_sfr_rdata,
	output logic             o_sfr_hit,
	// configuration ram port
	input  wire logic [15:0] i_xram_addr,
	input  wire logic        i_xram_wr,
	input  wire logic        i_xram_rd,
	input  wire logic [7:0]  i_xram_wdata,
	output logic      [7:0]  o_xram_rdata,
	output logic             o_xram_hit,
	// processor flash requests
	input  wire logic        i_mpu_write,
	input  wire logic        i_mpu_page_erase,
	input  wire logic [6:0]  i_mpu_page,
	output logic             o_mpu_write_ok,
	output logic             o_mpu_page_erase_ok,
	// emulator requests
	input  wire logic        i_emu_req,
	input  wire logic [2:0]  i_emu_op,
	input  wire logic [6:0]  i_emu_page,
	output logic             o_emu_grant,
	output logic             o_emu_refuse,
	output logic             o_emu_enable,
	output logic             o_emu_clock_en,
	// flash engine
	input  wire logic        i_bulk_erase_done,
	output logic             o_engine_program_ram_clear,
	output logic             o_code_protect_lock,
	output logic             o_preboot
);
	import fcs_pkg::*;

	// ==========================================================
	// state
	fcs_phase_t  phase;
	fcs_phase_t  next_phase;
	logic        code_protect_lock;
	logic        next_lock;
	logic [7:0]  flash_control;
	logic [7:0]  next_flash_control;
	logic [7:0]  config_one;
	logic [7:0]  next_config_one;
	logic        preboot_done;
	logic        sfr_sel;
	logic        cfg_sel;
	logic        emu_ok;
	logic        emu_page0;
	logic        mpu_page0;

	logic [7:0]  sfr_rdata_q;
	logic [7:0]  next_sfr_rdata;
	logic        sfr_hit_q;
	logic [7:0]  xram_rdata_q;
	logic [7:0]  next_xram_rdata;
	logic        xram_hit_q;
	logic        mpu_write_ok_q;
	logic        next_mpu_write_ok;
	logic        mpu_perase_ok_q;
	logic        next_mpu_perase_ok;
	logic        emu_grant_q;
	logic        next_emu_grant;
	logic        emu_refuse_q;
	logic        next_emu_refuse;
	logic        emu_enable_q;
	logic        next_emu_enable;
	logic        emu_clock_en_q;
	logic        next_emu_clock_en;
	logic        ram_clear_q;
	logic        next_ram_clear;
	logic        next_sfr_hit;
	logic        next_xram_hit;
	logic        preboot_q;
	logic        next_preboot;

	fcs_preboot_timer #(
		.LENGTH (PREBOOT_CYCLES),
		.CNT_W  (PREBOOT_CNT_W)
	) u_preboot (
		.i_core_clk (i_core_clk),
		.i_rst_n    (i_rst_n),
		.i_ce       (i_ce),
		.o_done     (preboot_done)
	);

	assign sfr_sel = (i_sfr_addr == SFR_FLASH_CONTROL);
	assign cfg_sel = (i_xram_addr == XADR_CONFIG_ONE);

	// ==========================================================
	// phase and protection bit
	always_comb
	begin
		next_phase = phase;
		next_lock  = code_protect_lock;
		case (phase)
			FCS_PREBOOT:
			begin
				if (i_sfr_wr && sfr_sel && i_sfr_wdata[FC_LOCK_BIT]
					&& !preboot_done)
				begin
					next_lock = 1'b1;
				end
				if (preboot_done)
				begin
					next_phase = FCS_RUN;
				end
			end
			FCS_RUN:
			begin
				if (i_bulk_erase_done)
				begin
					next_phase = FCS_ERASED;
				end
			end
			FCS_ERASED:
			begin
				// lock holds until the next reset
				next_phase = FCS_ERASED;
			end
			default:
			begin
				next_phase = FCS_PREBOOT;
			end
		endcase
	end

	// ==========================================================
	// register file
	always_comb
	begin
		next_flash_control = flash_control;
		next_config_one    = config_one;
		if (i_sfr_wr && sfr_sel)
		begin
			next_flash_control = i_sfr_wdata & FC_STORED_MASK;
		end
		if (i_xram_wr && cfg_sel)
		begin
			next_config_one = i_xram_wdata & CF1_STORED_MASK;
		end
		next_sfr_rdata = 8'h00;
		if (i_sfr_rd && sfr_sel)
		begin
			next_sfr_rdata = flash_control;
			next_sfr_rdata[FC_PREBOOT_BIT] = !preboot_done;
			next_sfr_rdata[FC_LOCK_BIT]    = code_protect_lock;
		end
		next_xram_rdata = 8'h00;
		if (i_xram_rd && cfg_sel)
		begin
			next_xram_rdata = config_one;
		end
	end

	// ==========================================================
	// access gating
	always_comb
	begin
		emu_page0 = (i_emu_page == 7'h00);
		mpu_page0 = (i_mpu_page == 7'h00);
		next_mpu_write_ok  = i_mpu_write
			&& !(code_protect_lock && mpu_page0);
		next_mpu_perase_ok = i_mpu_page_erase
			&& !(code_protect_lock && mpu_page0);
		emu_ok = 1'b0;
		if (phase != FCS_PREBOOT
			&& !config_one[CF1_ECK_OFF_BIT])
		begin
			if (!code_protect_lock)
			begin
				emu_ok = 1'b1;
			end
			else
			begin
				emu_ok = (i_emu_op == EMU_OP_BULK_ERASE);
			end
			if (i_emu_op == EMU_OP_NONE)
			begin
				emu_ok = 1'b0;
			end
			if (code_protect_lock && emu_page0
				&& (i_emu_op == EMU_OP_WRITE
				|| i_emu_op == EMU_OP_PAGE_ERASE))
			begin
				emu_ok = 1'b0;
			end
		end
		next_emu_grant  = i_emu_req && emu_ok;
		next_emu_refuse = i_emu_req && !emu_ok;
		next_ram_clear  = i_bulk_erase_done;
	end

	// ==========================================================
	// status and handshake next values
	always_comb
	begin
		next_sfr_hit      = i_sfr_rd && sfr_sel;
		next_xram_hit     = i_xram_rd && cfg_sel;
		next_emu_enable   = preboot_done
			&& !next_config_one[CF1_ECK_OFF_BIT];
		next_emu_clock_en =
			!next_config_one[CF1_ECK_OFF_BIT];
		// follows the phase so the pin and the gating agree
		next_preboot      = (next_phase == FCS_PREBOOT);
	end

	// ==========================================================
	// phase and protection registers
	always_ff @(posedge i_core_clk)
	begin
		if (!i_rst_n)
		begin
			phase             <= FCS_PREBOOT;
			code_protect_lock <= 1'b0;
			preboot_q         <= 1'b1;
		end
		else if (i_ce)
		begin
			phase             <= next_phase;
			code_protect_lock <= next_lock;
			preboot_q         <= next_preboot;
		end
	end

	// ==========================================================
	// registers
	always_ff @(posedge i_core_clk)
	begin
		if (!i_rst_n)
		begin
			flash_control     <= FC_RESET;
			config_one        <= CF1_RESET;
			sfr_rdata_q       <= 8'h00;
			sfr_hit_q         <= 1'b0;
			xram_rdata_q      <= 8'h00;
			xram_hit_q        <= 1'b0;
			mpu_write_ok_q    <= 1'b0;
			mpu_perase_ok_q   <= 1'b0;
			emu_grant_q       <= 1'b0;
			emu_refuse_q      <= 1'b0;
			emu_enable_q      <= 1'b0;
			emu_clock_en_q    <= 1'b0;
			ram_clear_q       <= 1'b0;
		end
		else if (i_ce)
		begin
			flash_control     <= next_flash_control;
			config_one        <= next_config_one;
			sfr_rdata_q       <= next_sfr_rdata;
			sfr_hit_q         <= next_sfr_hit;
			xram_rdata_q      <= next_xram_rdata;
			xram_hit_q        <= next_xram_hit;
			mpu_write_ok_q    <= next_mpu_write_ok;
			mpu_perase_ok_q   <= next_mpu_perase_ok;
			emu_grant_q       <= next_emu_grant;
			emu_refuse_q      <= next_emu_refuse;
			emu_enable_q      <= next_emu_enable;
			emu_clock_en_q    <= next_emu_clock_en;
			ram_clear_q       <= next_ram_clear;
		end
	end

	assign o_sfr_rdata                = sfr_rdata_q;
	assign o_sfr_hit                  = sfr_hit_q;
	assign o_xram_rdata               = xram_rdata_q;
	assign o_xram_hit                 = xram_hit_q;
	assign o_mpu_write_ok             = mpu_write_ok_q;
	assign o_mpu_page_erase_ok        = mpu_perase_ok_q;
	assign o_emu_grant                = emu_grant_q;
	assign o_emu_refuse               = emu_refuse_q;
	assign o_emu_enable               = emu_enable_q;
	assign o_emu_clock_en             = emu_clock_en_q;
	assign o_engine_program_ram_clear = ram_clear_q;
	assign o_code_protect_lock        = code_protect_lock;
	assign o_preboot                  = preboot_q;
endmodule : fcs_lock

// ===== sim/fcs_lock_checker.sv
/* port assertions for the flash code protection block
   assumes bind into fcs_lock, one clock, sync active-low reset */
module fcs_lock_checker
	import fcs_pkg::*;
(
	input wire logic       i_core_clk,
	input wire logic       i_rst_n,
	input wire logic       i_ce,
	input wire logic       i_mpu_write,
	input wire logic       i_mpu_page_erase,
	input wire logic [6:0] i_mpu_page,
	input wire logic       i_emu_req,
	input wire logic [2:0] i_emu_op,
	input wire logic       i_bulk_erase_done,
	input wire logic [7:0] o_sfr_rdata,
	input wire logic       o_sfr_hit,
	input wire logic       o_mpu_write_ok,
	input wire logic       o_mpu_page_erase_ok,
	input wire logic       o_emu_grant,
	input wire logic       o_emu_enable,
	input wire logic       o_emu_clock_en,
	input wire logic       o_engine_program_ram_clear,
	input wire logic       o_code_protect_lock,
	input wire logic       o_preboot
);
	timeunit 1ns;
	timeprecision 1ns;
	// ==========================================
	// protection rules
	default clocking cb @(posedge i_core_clk); endclocking
	default disable iff (!i_rst_n);
	a_preboot_len: assert property ($rose(i_rst_n) |->
		o_preboot ##[31:34] !o_preboot) else $error("preboot length");
	a_lock_in_preboot: assert property ($rose(o_code_protect_lock)
		|-> $past(o_preboot)) else $error("lock set after preboot");
	a_lock_sticky: assert property (o_code_protect_lock
		|=> o_code_protect_lock) else $error("lock cleared");
	a_reset_clears_lock: assert property (disable iff (1'b0)
		!i_rst_n |=> !o_code_protect_lock && o_preboot)
		else $error("reset left lock");
	a_emu_bulk_only: assert property (i_ce && i_emu_req &&
		o_code_protect_lock && i_emu_op != EMU_OP_BULK_ERASE
		|=> !o_emu_grant) else $error("locked emu op granted");
	a_emu_preboot_off: assert property (i_ce && i_emu_req &&
		o_preboot |=> !o_emu_grant) else $error("preboot emu granted");
	a_preboot_gate: assert property (o_preboot |->
		!o_emu_enable) else $error("emu enabled in preboot");
	a_clock_off_gate: assert property (!o_emu_clock_en |->
		!o_emu_enable) else $error("emu enabled, clock off");
	a_page0_write: assert property (i_ce && i_mpu_write &&
		i_mpu_page == 7'h00 && o_code_protect_lock |=> !o_mpu_write_ok)
		else $error("page zero write allowed");
	a_page0_erase: assert property (i_ce && i_mpu_page_erase &&
		i_mpu_page == 7'h00 && o_code_protect_lock
		|=> !o_mpu_page_erase_ok) else $error("page zero erase allowed");
	a_ram_clear: assert property (i_ce && i_bulk_erase_done
		|=> o_engine_program_ram_clear) else $error("ram not cleared");
	a_unused_zero: assert property (o_sfr_hit |->
		o_sfr_rdata[5:2] == 4'h0) else $error("unused bits set");
endmodule : fcs_lock_checker

bind fcs_lock fcs_lock_checker i_fcs_lock_checker (.*);

// ===== sim/fcs_emu_model.sv
/* emulator side: holds a request for every cycle the command is held
   assumes commands from the bench on the same clock */
module fcs_emu_model
(
	input  wire logic       i_core_clk,
	input  wire logic       i_go,
	input  wire logic [2:0] i_op,
	input  wire logic [6:0] i_page,
	output logic            o_req,
	output logic      [2:0] o_op,
	output logic      [6:0] o_page
);
	timeunit 1ns;
	timeprecision 1ns;
	// ==========================================
	// request driver; idle lines toggle
	initial
	begin
		o_req = 1'b0;
		o_op = 3'h0;
		o_page = 7'h00;
	end
	always @(posedge i_core_clk)
	begin
		o_req <= i_go;
		o_op <= i_go ? i_op : ~o_op;
		o_page <= i_go ? i_page : ~o_page;
	end
endmodule : fcs_emu_model

// ===== sim/fcs_lock_tb.sv
/* self-checking bench for fcs_lock with an emulator model
   assumes 10 MHz clock, ce high but for one freeze test */
module fcs_lock_tb;
	import fcs_pkg::*;
	timeunit 1ns;
	timeprecision 1ns;
	logic i_core_clk, i_rst_n, i_ce, i_sfr_wr, i_sfr_rd, i_xram_wr;
	logic i_xram_rd, i_mpu_write, i_mpu_page_erase, i_emu_req, go;
	logic i_bulk_erase_done, o_sfr_hit, o_xram_hit, o_mpu_write_ok;
	logic o_mpu_page_erase_ok, o_emu_grant, o_emu_refuse, o_emu_enable;
	logic o_emu_clock_en, o_engine_program_ram_clear, o_preboot;
	logic o_code_protect_lock;
	logic [7:0]  i_sfr_addr, i_sfr_wdata, i_xram_wdata, o_sfr_rdata;
	logic [7:0]  o_xram_rdata, d;
	logic [15:0] i_xram_addr;
	logic [6:0]  i_mpu_page, i_emu_page, pg;
	logic [2:0]  i_emu_op, op;
	logic [8:0]  r9;
	logic [1:0]  r2;
	int          bad_count, tests_run, i;
	fcs_lock i_fcs_lock (.*);
	fcs_emu_model i_fcs_emu_model (.i_core_clk(i_core_clk), .i_go(go),
		.i_op(op), .i_page(pg), .o_req(i_emu_req), .o_op(i_emu_op),
		.o_page(i_emu_page));
	// ==========================================
	// helpers
	function automatic logic [1:0] exp_emu(logic [2:0] o, logic lk,
		logic pb, logic ck);
		logic g;
		g = !pb && ck && o != EMU_OP_NONE && (!lk || o == EMU_OP_BULK_ERASE);
		return {g, !g};
	endfunction : exp_emu
	task chk(input logic [8:0] seen, input logic [8:0] exp);
		tests_run++;
		if (seen !== exp)
		begin
			bad_count++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk
	task give_verdict;
		$display("bad_count=%0d tests_run=%0d", bad_count, tests_run);
		if (bad_count == 0 && tests_run > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : give_verdict
	task rst;
		@(posedge i_core_clk);
		i_rst_n <= 1'b0;
		repeat (3) @(posedge i_core_clk);
		i_rst_n <= 1'b1;
		#1;
	endtask : rst
	task acc(input logic x, input logic w, input logic [15:0] a,
		input logic [7:0] wd);
		@(posedge i_core_clk);
		i_sfr_addr <= a[7:0];
		i_xram_addr <= a;
		i_sfr_wdata <= wd;
		i_xram_wdata <= wd;
		{i_xram_wr, i_xram_rd, i_sfr_wr, i_sfr_rd} <= {x&w, x&!w, !x&w, !x&!w};
		@(posedge i_core_clk);
		{i_xram_wr, i_xram_rd, i_sfr_wr, i_sfr_rd} <= 4'h0;
		#1;
		r9 = x ? {o_xram_hit, o_xram_rdata} : {o_sfr_hit, o_sfr_rdata};
	endtask : acc
	task emu(input logic [2:0] o, input logic [6:0] p);
		@(posedge i_core_clk);
		go <= 1'b1;
		op <= o;
		pg <= p;
		repeat (2) @(posedge i_core_clk);
		go <= 1'b0;
		#1;
		r2 = {o_emu_grant, o_emu_refuse};
	endtask : emu
	task mpu(input logic [6:0] p, input logic lk);
		@(posedge i_core_clk);
		{i_mpu_write, i_mpu_page_erase, i_mpu_page} <= {2'b11, p};
		@(posedge i_core_clk);
		{i_mpu_write, i_mpu_page_erase} <= 2'b00;
		#1;
		chk({7'h0, o_mpu_write_ok, o_mpu_page_erase_ok},
			{7'h0, {2{!(lk && p == 7'h00)}}});
	endtask : mpu
	task bulk;
		@(posedge i_core_clk);
		i_bulk_erase_done <= 1'b1;
		@(posedge i_core_clk);
		i_bulk_erase_done <= 1'b0;
		#1;
		chk({8'h0, o_engine_program_ram_clear}, 9'h001);
	endtask : bulk
	// ==========================================
	// stimulus
	initial
	begin
		i_core_clk = 1'b0;
		forever #50 i_core_clk = ~i_core_clk;
	end
	initial
	begin
		repeat (5000) @(posedge i_core_clk);
		bad_count++;
		give_verdict;
	end
	initial
	begin
		{i_rst_n, i_sfr_wr, i_sfr_rd, i_xram_wr, i_xram_rd, go} = 6'h0;
		{i_mpu_write, i_mpu_page_erase, i_bulk_erase_done} = 3'h0;
		{i_sfr_addr, i_sfr_wdata, i_xram_wdata, i_xram_addr} = 40'h0;
		{i_mpu_page, op, pg, bad_count, tests_run} = 0;
		i_ce = 1'b1;
		d = 8'($urandom(32'h5828cefa));
		rst;
		acc(0, 0, 16'(SFR_FLASH_CONTROL), 8'h00);
		chk(r9, 9'h180);
		chk({7'h0, o_preboot, o_emu_enable}, 9'h002);
		emu(EMU_OP_READ, 7'h01);
		chk({7'h0, r2}, {7'h0, exp_emu(EMU_OP_READ, 0, 1, 1)});
		acc(0, 1, 16'(SFR_FLASH_CONTROL), 8'h43);
		acc(0, 1, 16'(SFR_FLASH_CONTROL), 8'h3c);
		chk({8'h0, o_code_protect_lock}, 9'h001);
		repeat (40) @(posedge i_core_clk);
		@(posedge i_core_clk);
		i_ce <= 1'b0;
		acc(0, 1, 16'(SFR_FLASH_CONTROL), 8'h03);
		@(posedge i_core_clk);
		i_ce <= 1'b1;
		acc(0, 0, 16'(SFR_FLASH_CONTROL), 8'h00);
		chk(r9, 9'h140);
		chk({6'h0, o_preboot, o_emu_enable, o_emu_clock_en}, 9'h003);
		for (i = 0; i < 6; i++)
		begin
			emu(3'(i), 7'($urandom) & 7'h03);
			chk({7'h0, r2}, {7'h0, exp_emu(3'(i), 1, 0, 1)});
		end
		mpu(7'h00, 1'b1);
		mpu(7'($urandom) | 7'h01, 1'b1);
		bulk;
		chk({8'h0, o_code_protect_lock}, 9'h001);
		rst;
		chk({8'h0, o_code_protect_lock}, 9'h000);
		repeat (40) @(posedge i_core_clk);
		acc(0, 1, 16'(SFR_FLASH_CONTROL), 8'h40);
		chk({8'h0, o_code_protect_lock}, 9'h000);
		for (i = 0; i < 6; i++)
		begin
			emu(3'(i), 7'h00);
			chk({7'h0, r2}, {7'h0, exp_emu(3'(i), 0, 0, 1)});
		end
		mpu(7'h00, 1'b0);
		bulk;
		acc(1, 0, XADR_CONFIG_ONE, 8'h00);
		d = {r9[7], d[6:0]} | 8'h20;
		acc(1, 1, XADR_CONFIG_ONE, d);
		chk({7'h0, o_emu_enable, o_emu_clock_en}, 9'h000);
		acc(1, 0, XADR_CONFIG_ONE, 8'h00);
		chk(r9, {1'b1, d & CF1_STORED_MASK});
		emu(EMU_OP_BULK_ERASE, 7'h00);
		chk({7'h0, r2}, {7'h0, exp_emu(EMU_OP_BULK_ERASE, 0, 0, 0)});
		acc(1, 0, XADR_CONFIG_ONE + 16'h0001, 8'h00);
		chk({8'h0, r9[8]}, 9'h000);
		give_verdict;
	end
endmodule : fcs_lock_tb
